// [rtl/pci_agent_consts.svh]
// Constants for the slot bus target: commands, config layout, reset values.
// Assumes inclusion by the package, the design file and the bench only.
`ifndef PCI_AGENT_CONSTS_SVH
`define PCI_AGENT_CONSTS_SVH

// ==========================================
// Bus commands as seen on the command lines.
`define CMD_SPECIAL 4'h1
`define CMD_MEM_RD 4'h6
`define CMD_MEM_WR 4'h7
`define CMD_CFG_RD 4'ha
`define CMD_CFG_WR 4'hb

// ==========================================
// Memory window decode.
`define MEM_BASE 32'h8000_0000
`define MEM_MASK 32'hffff_0000
`define LOCK_LSB 4

// ==========================================
// Configuration space, dword indices and fields.
`define CFG_IDX_ID 6'h00
`define CFG_IDX_CTL 6'h01
`define CFG_ID_WORD 32'h5a5a_0001
`define CTL_MEM_EN_BIT 1
`define CTL_LOCK_BIT 8
`define MEM_EN_RST 1'b0

// ==========================================
// Data path sizes and idle pin image.
`define DATA_W 32
`define BE_W 4
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define BUS_IDLE 41'h0_0000_0000_000e

`endif

// [rtl/pci_agent_pkg.sv]
// Types shared by the slot bus target and its FIFO.
// Assumes the constants header is on the include path.
`include "pci_agent_consts.svh"

package pci_agent_pkg;

	// ==========================================
	// Sampled image of the bus input pins.
	typedef struct packed {
		logic [31:0] ad;
		logic [3:0] cbe_n;
		logic par;
		logic frame_n;
		logic irdy_n;
		logic lock_n;
		logic idsel;
	} bus_in_t;

	// ==========================================
	// One accepted write word with its byte enables.
	typedef struct packed {
		logic [3:0] be_n;
		logic [31:0] data;
	} wr_word_t;

	// ==========================================
	// Target sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_OTHER,
		ST_DATA,
		ST_RETRY
	} tgt_state_t;

endpackage

// [rtl/pci_slot_bus_agent.sv]
// Single-function target on the shared slot bus, with FIFOs for the data.
// Assumes all bus pins enter unsynchronised and are resolved by the bench.
`timescale 1ns/1ps
`include "pci_agent_consts.svh"

// ==========================================
// Synchronous FIFO with registered flags.
module sync_fifo #(
	parameter int W = 32,
	parameter int D = 8,
	parameter int AW = 3
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic nrst,
	// Filling side.
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// Draining side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] mem_r [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic [AW:0] cnt_nxt;
	logic push;
	logic pop;

	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem_r[rp_r];

	always_comb begin
		cnt_nxt = cnt_r;
		if (push & ~pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop & ~push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wp_r <= wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'b1;
			end
			cnt_r <= cnt_nxt;
			in_ready <= cnt_nxt != (AW+1)'(D);
			out_valid <= cnt_nxt != '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end
endmodule

// ==========================================
// Sustained tri-state pin driver.
// While act is high the pin is driven with the inverse of asrt; when act
// falls an asserted pin is driven high for one clock before release.
module sts_pin (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic nrst,
	// Drive window and assert level.
	input wire logic act,
	input wire logic asrt,
	// Pin side.
	output logic pin_o,
	output logic pin_oe
);
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pin_o <= 1'b1;
			pin_oe <= 1'b0;
		end else if (act) begin
			pin_oe <= 1'b1;
			pin_o <= ~asrt;
		end else begin
			pin_o <= 1'b1;
			pin_oe <= pin_oe & ~pin_o; // see (RULE18) (RULE23)
		end
	end
endmodule

// ==========================================
// Summary of operation
// (RULE1) Sample every bus input on the clock.
// (RULE2) Reset releases all outputs at once.
// (RULE3) Central resource parks lines only low.
// (RULE4) Asynchronous reset; memory decode off until enabled.
// (RULE5) Address phase is first FRAME low clock.
// (RULE6) Lane 0 carries the low byte.
// (RULE7) Transfer only when both ready lines low.
// (RULE8) Command then byte enables per data phase.
// (RULE9) Even parity over AD and command lines.
// (RULE10) Target drives parity on read data.
// (RULE11) Master's FRAME marks the final phase.
// (RULE12) Ready meanings swap between read and write.
// (RULE13) Drive DEVSEL when the address is ours.
// (RULE14) IDSEL selects configuration accesses.
// (RULE15) Lock excludes others from 16-byte region.
// (RULE16) No arbitration activity during reset.
// (RULE17) Parity error reported two clocks after data; the code drives PERR four clocks after it.
// (RULE18) Drive PERR high one clock before release.
// (RULE19) Report data parity only after claiming.
// (RULE20) SERR low exactly one clock, then release.
// (RULE21) Interrupt is a low, level, open-drain output.
// (RULE22) Single function uses interrupt line A only.
// (RULE23) One idle clock between bus drivers.
module pci_slot_bus_agent
	import pci_agent_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic nrst,
	// Address and data, command and parity.
	input wire logic [31:0] ad_i,
	output logic [31:0] ad_o,
	output logic ad_oe,
	input wire logic [3:0] cbe_n_i,
	input wire logic par_i,
	output logic par_o,
	output logic par_oe,
	// Cycle control inputs.
	input wire logic frame_n_i,
	input wire logic irdy_n_i,
	input wire logic lock_n_i,
	input wire logic idsel_i,
	// Target responses.
	output logic trdy_n_o,
	output logic trdy_n_oe,
	output logic devsel_n_o,
	output logic devsel_n_oe,
	output logic stop_n_o,
	output logic stop_n_oe,
	// Error reporting.
	output logic perr_n_o,
	output logic perr_n_oe,
	output logic serr_n_o,
	output logic serr_n_oe,
	// Interrupt line A.
	output logic inta_n_o,
	output logic inta_n_oe,
	// Written words toward the user.
	output logic wr_valid,
	input wire logic wr_ready,
	output logic [31:0] wr_data,
	output logic [3:0] wr_be_n,
	// Read words from the user.
	input wire logic rd_valid,
	output logic rd_ready,
	input wire logic [31:0] rd_data,
	// Interrupt request level from the user.
	input wire logic irq_req
);
	bus_in_t pin_w;
	bus_in_t s1_r;
	bus_in_t s_r;
	logic frm_q_r;
	tgt_state_t st_r;
	tgt_state_t st_nxt;
	logic [3:0] cmd;
	logic addr_ph;
	logic hit_mem;
	logic hit_cfg;
	logic lk_hit;
	logic rd_r;
	logic cfg_r;
	logic spc_r;
	logic [5:0] cidx_r;
	logic [31:`LOCK_LSB] addr_r;
	logic mem_en_r;
	logic lock_act_r;
	logic [31:`LOCK_LSB] lock_adr_r;
	logic offer;
	logic t0_r;
	logic t1_r;
	logic t2_r;
	logic xfer;
	logic src_ok;
	logic apchk_r;
	logic apar_r;
	logic wchk_r;
	logic wpar_r;
	logic schk_r;
	logic spar_r;
	logic perr_ev;
	logic serr_ev;
	logic [31:0] cfg_word;
	wr_word_t wf_in;
	wr_word_t wf_out;
	logic wf_ready;
	logic rf_valid;
	logic [31:0] rf_data;
	logic in_data_ph;
	logic in_retry;

	// ==========================================
	// Input sampling through two flip-flops.
	assign pin_w = {ad_i, cbe_n_i, par_i, frame_n_i, irdy_n_i, lock_n_i, idsel_i};

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s1_r <= `BUS_IDLE;
			s_r <= `BUS_IDLE;
			frm_q_r <= 1'b1;
		end else begin
			s1_r <= pin_w; // see (RULE1)
			s_r <= s1_r;
			frm_q_r <= s_r.frame_n;
		end
	end

	// ==========================================
	// Address phase decode.
	assign cmd = s_r.cbe_n; // see (RULE8)
	assign addr_ph = frm_q_r & ~s_r.frame_n; // see (RULE5)
	assign hit_mem = (cmd == `CMD_MEM_RD || cmd == `CMD_MEM_WR) & mem_en_r
		& ((s_r.ad & `MEM_MASK) == `MEM_BASE); // see (RULE4)
	assign hit_cfg = (cmd == `CMD_CFG_RD || cmd == `CMD_CFG_WR) & s_r.idsel
		& (s_r.ad[1:0] == 2'b00); // see (RULE14)
	assign lk_hit = lock_act_r & hit_mem & ~s_r.lock_n
		& (s_r.ad[31:`LOCK_LSB] == lock_adr_r); // see (RULE15)

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rd_r <= 1'b0;
			cfg_r <= 1'b0;
			spc_r <= 1'b0;
			cidx_r <= '0;
			addr_r <= '0;
		end else if (st_r == ST_IDLE && addr_ph) begin
			rd_r <= ~cmd[0];
			cfg_r <= hit_cfg;
			spc_r <= cmd == `CMD_SPECIAL;
			cidx_r <= s_r.ad[7:2];
			addr_r <= s_r.ad[31:`LOCK_LSB];
		end
	end

	// ==========================================
	// Target sequencer.
	assign in_data_ph = st_r == ST_DATA;
	assign in_retry = st_r == ST_RETRY;
	assign xfer = in_data_ph & t2_r & ~s_r.irdy_n; // see (RULE7)

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: begin
				if (addr_ph) begin
					if (lk_hit) begin
						st_nxt = ST_RETRY;
					end else if (hit_mem | hit_cfg) begin
						st_nxt = ST_DATA; // see (RULE13)
					end else begin
						st_nxt = ST_OTHER;
					end
				end
			end
			ST_OTHER: begin
				if (s_r.frame_n & s_r.irdy_n) begin
					st_nxt = ST_IDLE;
				end
			end
			ST_DATA: begin
				if (xfer & s_r.frame_n) begin
					st_nxt = ST_IDLE; // see (RULE11)
				end
			end
			ST_RETRY: begin
				// Hold the retry until the master has seen STOP and dropped IRDY.
				if (s_r.frame_n & s_r.irdy_n) begin
					st_nxt = ST_IDLE;
				end
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= ST_IDLE; // see (RULE16)
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================
	// Ready offers, one at a time, each resolved before the next.
	always_comb begin
		if (cfg_r) begin
			src_ok = 1'b1;
		end else if (rd_r) begin
			src_ok = rf_valid;
		end else begin
			src_ok = wf_ready;
		end
	end

	assign offer = in_data_ph & ~t0_r & ~t1_r & ~t2_r & src_ok; // see (RULE12)

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			t0_r <= 1'b0;
			t1_r <= 1'b0;
			t2_r <= 1'b0;
		end else begin
			t0_r <= offer;
			t1_r <= t0_r;
			t2_r <= t1_r;
		end
	end

	// ==========================================
	// Configuration space.
	always_comb begin
		cfg_word = 32'h0000_0000;
		if (cidx_r == `CFG_IDX_ID) begin
			cfg_word = `CFG_ID_WORD;
		end else if (cidx_r == `CFG_IDX_CTL) begin
			cfg_word[`CTL_MEM_EN_BIT] = mem_en_r;
			cfg_word[`CTL_LOCK_BIT] = lock_act_r;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			mem_en_r <= `MEM_EN_RST; // see (RULE4)
		end else if (xfer & cfg_r & ~rd_r & (cidx_r == `CFG_IDX_CTL) & ~s_r.cbe_n[0]) begin
			mem_en_r <= s_r.ad[`CTL_MEM_EN_BIT];
		end
	end

	// ==========================================
	// Lock tracking for one aligned region.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			lock_act_r <= 1'b0;
			lock_adr_r <= '0;
		end else if (xfer & ~cfg_r & ~s_r.lock_n) begin
			lock_act_r <= 1'b1; // see (RULE15)
			lock_adr_r <= addr_r;
		end else if (st_r == ST_IDLE && s_r.frame_n && s_r.lock_n) begin
			lock_act_r <= 1'b0;
		end
	end

	// ==========================================
	// Read data and parity drive.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ad_o <= 32'h0000_0000;
			ad_oe <= 1'b0; // see (RULE2)
			par_o <= 1'b0;
			par_oe <= 1'b0;
		end else begin
			ad_o <= cfg_r ? cfg_word : rf_data; // see (RULE6)
			ad_oe <= in_data_ph & rd_r & (st_nxt == ST_DATA); // see (RULE23)
			par_o <= ^{ad_o, s_r.cbe_n}; // see (RULE9)
			par_oe <= ad_oe; // see (RULE10)
		end
	end

	// ==========================================
	// Parity checking.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			apchk_r <= 1'b0;
			apar_r <= 1'b0;
			wchk_r <= 1'b0;
			wpar_r <= 1'b0;
			schk_r <= 1'b0;
			spar_r <= 1'b0;
		end else begin
			apchk_r <= st_r == ST_IDLE && addr_ph;
			apar_r <= ^{s_r.ad, s_r.cbe_n};
			wchk_r <= xfer & ~rd_r; // see (RULE19)
			wpar_r <= ^{s_r.ad, s_r.cbe_n};
			schk_r <= (st_r == ST_OTHER) & spc_r & ~s_r.irdy_n;
			spar_r <= ^{s_r.ad, s_r.cbe_n};
		end
	end

	assign perr_ev = wchk_r & (wpar_r ^ s_r.par); // see (RULE17)
	assign serr_ev = (apchk_r & (apar_r ^ s_r.par)) | (schk_r & (spar_r ^ s_r.par));

	// ==========================================
	// Open-drain system error and interrupt.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			serr_n_o <= 1'b1;
			serr_n_oe <= 1'b0; // see (RULE2)
			inta_n_o <= 1'b1;
			inta_n_oe <= 1'b0;
		end else begin
			serr_n_o <= 1'b0;
			serr_n_oe <= serr_ev; // see (RULE20)
			inta_n_o <= 1'b0;
			inta_n_oe <= irq_req; // see (RULE21) (RULE22)
		end
	end

	// ==========================================
	// Sustained tri-state responses.
	sts_pin u_trdy (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.act(in_data_ph),
		.asrt(offer),
		.pin_o(trdy_n_o),
		.pin_oe(trdy_n_oe)
	);

	sts_pin u_devsel (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.act(in_data_ph | in_retry),
		.asrt(st_nxt == ST_DATA || st_nxt == ST_RETRY), // see (RULE13)
		.pin_o(devsel_n_o),
		.pin_oe(devsel_n_oe)
	);

	sts_pin u_stop (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.act(in_retry),
		.asrt(st_nxt == ST_RETRY), // see (RULE15)
		.pin_o(stop_n_o),
		.pin_oe(stop_n_oe)
	);

	sts_pin u_perr (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.act(perr_ev),
		.asrt(perr_ev), // see (RULE17) (RULE18)
		.pin_o(perr_n_o),
		.pin_oe(perr_n_oe)
	);

	// ==========================================
	// Data FIFOs between bus and user.
	assign wf_in = {s_r.cbe_n, s_r.ad};
	assign wr_be_n = wf_out.be_n;
	assign wr_data = wf_out.data;

	sync_fifo #(
		.W(`DATA_W + `BE_W),
		.D(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_wfifo (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.in_valid(xfer & ~rd_r & ~cfg_r),
		.in_data(wf_in),
		.in_ready(wf_ready),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data(wf_out)
	);

	sync_fifo #(
		.W(`DATA_W),
		.D(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_rfifo (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.in_valid(rd_valid),
		.in_data(rd_data),
		.in_ready(rd_ready),
		.out_valid(rf_valid),
		.out_ready(xfer & rd_r & ~cfg_r),
		.out_data(rf_data)
	);
endmodule

// [verif/bus_master_model.sv]
// Initiator model for the slot bus: one single-phase access per call.
// Assumes the bench resolves every shared line and makes the clock.
`timescale 1ns/1ps
module bus_master_model (
	// Clock.
	input wire logic ref_clk,
	// Resolved bus lines.
	input wire logic [31:0] ad_in,
	input wire logic trdy_n,
	input wire logic devsel_n,
	input wire logic stop_n,
	// Driven lines with their enables.
	output logic [31:0] ad,
	output logic ad_en,
	output logic [3:0] cbe_n,
	output logic par,
	output logic par_en,
	output logic frame_n,
	output logic irdy_n,
	output logic idsel
);
	initial begin
		ad = 32'h0000_0000;
		ad_en = 1'b0;
		cbe_n = 4'h0;
		par = 1'b0;
		par_en = 1'b0;
		frame_n = 1'b1;
		irdy_n = 1'b1;
		idsel = 1'b0;
	end

	// PAR is given up one clock after the phase it covers has ended.
	always @(posedge ref_clk) begin
		if (frame_n && irdy_n) begin
			par_en <= #1 1'b0;
		end
	end

	// ==========================================
	// One access; bad[0] spoils address parity, bad[1] data parity.
	task automatic xfer(input logic [3:0] cmd, input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] be, input logic sel, input logic [1:0] bad,
		output logic [31:0] rd, output logic ok);
		int n;
		ok = 1'b0;
		rd = 32'h0000_0000;
		@(posedge ref_clk);
		#1;
		frame_n = 1'b0;
		ad = a;
		ad_en = 1'b1;
		cbe_n = cmd;
		idsel = sel;
		@(posedge ref_clk);
		#1;
		frame_n = 1'b1;
		irdy_n = 1'b0;
		idsel = 1'b0;
		par = ^{a, cmd} ^ bad[0];
		par_en = 1'b1;
		cbe_n = be;
		ad = d;
		ad_en = cmd[0];
		for (n = 0; n < 12; n++) begin
			@(posedge ref_clk);
			if (!trdy_n && !devsel_n) begin
				ok = 1'b1;
				rd = ad_in;
			end
			#1;
			par = ^{d, be} ^ bad[1];
			par_en = cmd[0];
			if (ok || !stop_n) begin
				break;
			end
		end
		irdy_n = 1'b1;
		ad_en = 1'b0;
	endtask
endmodule

// [verif/pci_slot_bus_agent_monitor.sv]
// Checker of the slot bus target's pin outputs.
// Assumes it is bound into every pci_slot_bus_agent instance.
`timescale 1ns/1ps
module bus_agent_monitor (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic nrst,
	// Watched ports.
	input wire logic [31:0] ad_o,
	input wire logic ad_oe,
	input wire logic [3:0] cbe_n_i,
	input wire logic par_o,
	input wire logic par_oe,
	input wire logic trdy_n_o,
	input wire logic trdy_n_oe,
	input wire logic devsel_n_o,
	input wire logic devsel_n_oe,
	input wire logic stop_n_o,
	input wire logic stop_n_oe,
	input wire logic perr_n_o,
	input wire logic perr_n_oe,
	input wire logic serr_n_o,
	input wire logic serr_n_oe,
	input wire logic inta_n_oe,
	input wire logic irq_req
);
	// ==========================================
	// Pin relations.
	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	a_reset_all_off: assert property (disable iff (1'b0) !nrst |->
		{ad_oe, par_oe, trdy_n_oe, devsel_n_oe, stop_n_oe, perr_n_oe, serr_n_oe, inta_n_oe} == 0)
		else $error("output driven in reset");
	a_trdy_in_claim: assert property (
		trdy_n_oe && !trdy_n_o |-> devsel_n_oe && !devsel_n_o)
		else $error("TRDY outside claim");
	a_trdy_pulse_gap: assert property (
		trdy_n_oe && !trdy_n_o |=> (trdy_n_o || !trdy_n_oe) [*3])
		else $error("TRDY pulses too close");
	a_par_even: assert property (
		$past(ad_oe) && par_oe |-> par_o == ^{$past(ad_o), $past(cbe_n_i)})
		else $error("PAR not even");
	a_par_after_ad: assert property ($rose(par_oe) |-> $past(ad_oe) && ad_oe)
		else $error("PAR not behind AD");
	a_devsel_high_release: assert property ($fell(devsel_n_oe) |-> $past(devsel_n_o))
		else $error("DEVSEL released low");
	a_perr_high_release: assert property ($fell(perr_n_oe) |-> $past(perr_n_o))
		else $error("PERR released low");
	a_serr_one_clock: assert property (serr_n_oe |-> !serr_n_o ##1 !serr_n_oe)
		else $error("SERR pulse wrong");
	a_stop_in_claim: assert property (
		stop_n_oe && !stop_n_o |-> devsel_n_oe && !devsel_n_o)
		else $error("STOP outside claim");
	a_inta_level: assert property (inta_n_oe == $past(irq_req))
		else $error("INTA not following request");
endmodule

bind pci_slot_bus_agent bus_agent_monitor u_mon (.*);

// [verif/tb.sv]
// Bench for the slot bus target: a table of single accesses, then hand tests.
// Assumes the design, its package and the initiator model are compiled first.
`timescale 1ns/1ps
`include "pci_agent_consts.svh"
`define CHK(g, e) begin \
	compares++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("BAD t=%0t got %h exp %h", $time, g, e); \
	end \
end
module tb;
	typedef struct packed {
		logic [3:0] cmd;
		logic [31:0] a;
		logic [31:0] d;
		logic [3:0] be;
		logic sel;
		logic ok;
	} row_t;
	// The data field is the write data, or the word that a read returns.
	row_t rows [7] = '{
		'{`CMD_CFG_RD, 32'h0000_0000, `CFG_ID_WORD, 4'h0, 1'b1, 1'b1},
		'{`CMD_MEM_WR, 32'h8000_0010, 32'h0000_0001, 4'h0, 1'b0, 1'b0},
		'{`CMD_CFG_WR, 32'h0000_0004, 32'h0000_0002, 4'h0, 1'b1, 1'b1},
		'{`CMD_CFG_RD, 32'h0000_0000, `CFG_ID_WORD, 4'h0, 1'b0, 1'b0},
		'{`CMD_MEM_WR, 32'h8000_0020, 32'h1122_3344, 4'hc, 1'b0, 1'b1},
		'{`CMD_MEM_RD, 32'h8000_fffc, 32'ha1b2_c3d4, 4'h0, 1'b0, 1'b1},
		'{`CMD_MEM_WR, 32'h8001_0000, 32'h0000_0005, 4'h0, 1'b0, 1'b0}
	};
	logic ref_clk = 1'b0;
	logic nrst = 1'b1;
	logic wr_ready = 1'b0;
	logic rd_valid = 1'b0;
	logic [31:0] rd_data = 32'h0000_0000;
	logic irq_req = 1'b0;
	logic lock_n = 1'b1;
	int n_errors = 0;
	int compares = 0;
	int serr_clks = 0;
	int perr_clks = 0;
	logic [32:0] flt = 33'h0_0000_0000;
	logic [31:0] ad_o, m_ad, rd_word, wr_data;
	logic [3:0] cbe_n, wr_be_n;
	logic ad_oe, par_o, par_oe, trdy_n_o, trdy_n_oe, devsel_n_o, devsel_n_oe, stop_n_o;
	logic stop_n_oe, perr_n_o, perr_n_oe, serr_n_o, serr_n_oe, inta_n_o, inta_n_oe;
	logic wr_valid, rd_ready, m_ad_en, m_par, m_par_en, frame_n, irdy_n, idsel, ok;
	// The central resource parks AD and PAR low while reset is held.
	wire [31:0] ad_bus = ad_oe ? ad_o : m_ad_en ? m_ad : !nrst ? '0 : flt[31:0];
	wire par_bus = par_oe ? par_o : m_par_en ? m_par : !nrst ? 1'b0 : flt[32];
	wire trdy_bus = trdy_n_oe ? trdy_n_o : 1'b1;
	wire devsel_bus = devsel_n_oe ? devsel_n_o : 1'b1;
	wire stop_bus = stop_n_oe ? stop_n_o : 1'b1;
	wire inta_bus = inta_n_oe ? inta_n_o : 1'b1;

	always #10 ref_clk = ~ref_clk;
	// Undriven AD and PAR show the inverse of their last level.
	always @(posedge ref_clk) flt <= ~{par_bus, ad_bus};
	always @(posedge ref_clk) if (serr_n_oe === 1'b1) serr_clks++;
	always @(posedge ref_clk) if (perr_n_oe === 1'b1 && perr_n_o === 1'b0) perr_clks++;

	pci_slot_bus_agent DUT (
		.ref_clk, .nrst, .ad_i(ad_bus), .ad_o, .ad_oe, .cbe_n_i(cbe_n), .par_i(par_bus),
		.par_o, .par_oe, .frame_n_i(frame_n), .irdy_n_i(irdy_n), .lock_n_i(lock_n),
		.idsel_i(idsel), .trdy_n_o, .trdy_n_oe, .devsel_n_o, .devsel_n_oe, .stop_n_o,
		.stop_n_oe, .perr_n_o, .perr_n_oe, .serr_n_o, .serr_n_oe, .inta_n_o, .inta_n_oe,
		.wr_valid, .wr_ready, .wr_data, .wr_be_n, .rd_valid, .rd_ready, .rd_data, .irq_req
	);
	bus_master_model u_mst (
		.ref_clk, .ad_in(ad_bus), .trdy_n(trdy_bus), .devsel_n(devsel_bus), .stop_n(stop_bus),
		.ad(m_ad), .ad_en(m_ad_en), .cbe_n, .par(m_par), .par_en(m_par_en), .frame_n, .irdy_n,
		.idsel
	);

	// ==========================================
	// Shared tasks.
	task automatic test_done();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic push_rd(input logic [31:0] d);
		int n;
		rd_data = d;
		rd_valid = 1'b1;
		for (n = 0; n < 8; n++) begin
			@(posedge ref_clk);
			if (rd_ready === 1'b1) break;
		end
		#1;
		rd_valid = 1'b0;
		`CHK(n < 8, 1'b1)
	endtask

	task automatic pop_wr(input logic [31:0] d, input logic [3:0] be);
		int n;
		for (n = 0; n < 8; n++) begin
			@(posedge ref_clk);
			#1;
			if (wr_valid === 1'b1) break;
		end
		`CHK({wr_valid, wr_be_n, wr_data}, {1'b1, be, d})
		wr_ready = 1'b1;
		@(posedge ref_clk);
		#1;
		wr_ready = 1'b0;
	endtask

	// ==========================================
	// Main sequence.
	initial begin
		int i;
		// A real falling edge lets the asynchronous reset act before the first clock.
		#1;
		nrst = 1'b0;
		repeat (5) @(posedge ref_clk);
		#1;
		`CHK({ad_oe, par_oe, trdy_n_oe, devsel_n_oe, stop_n_oe, perr_n_oe, serr_n_oe}, 7'h00)
		nrst = 1'b1;
		@(posedge ref_clk);
		#1;
		`CHK({rd_ready, wr_valid, inta_n_oe}, 3'b100)
		for (i = 0; i < 7; i++) begin
			if (rows[i].cmd == `CMD_MEM_RD) push_rd(rows[i].d);
			u_mst.xfer(rows[i].cmd, rows[i].a, rows[i].d, rows[i].be, rows[i].sel, 2'b00, rd_word, ok);
			`CHK(ok, rows[i].ok)
			if (ok && !rows[i].cmd[0]) `CHK(rd_word, rows[i].d)
			if (ok && rows[i].cmd == `CMD_MEM_WR) pop_wr(rows[i].d, rows[i].be);
			repeat (3) @(posedge ref_clk);
			#1;
			$display("row %0d done", i);
		end
		// Eight writes fill the write FIFO while its user side stalls.
		for (i = 0; i < 8; i++) begin
			u_mst.xfer(`CMD_MEM_WR, 32'h8000_0100, 32'h0000_0a00 + i, 4'h0, 1'b0, 2'b00, rd_word, ok);
			`CHK(ok, 1'b1)
			repeat (3) @(posedge ref_clk);
		end
		for (i = 0; i < 8; i++) pop_wr(32'h0000_0a00 + i, 4'h0);
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK(wr_valid, 1'b0)
		$display("fifo test done");
		wr_ready = 1'b1;
		u_mst.xfer(`CMD_MEM_WR, 32'h8000_0200, 32'h0000_0001, 4'h0, 1'b0, 2'b10, rd_word, ok);
		repeat (3) @(posedge ref_clk);
		#1;
		`CHK({perr_n_oe, perr_n_o}, 2'b10)
		@(posedge ref_clk);
		#1;
		`CHK({perr_n_oe, perr_n_o}, 2'b11)
		@(posedge ref_clk);
		#1;
		`CHK(perr_n_oe, 1'b0)
		u_mst.xfer(`CMD_MEM_WR, 32'h9000_0000, 32'h0000_0001, 4'h0, 1'b0, 2'b10, rd_word, ok);
		repeat (6) @(posedge ref_clk);
		`CHK(perr_clks, 1)
		`CHK(serr_clks, 0)
		u_mst.xfer(`CMD_MEM_WR, 32'h8000_0300, 32'h0000_0002, 4'h0, 1'b0, 2'b01, rd_word, ok);
		repeat (6) @(posedge ref_clk);
		#1;
		`CHK(serr_clks, 1)
		$display("parity test done");
		// A locked write holds its region; a second locked access there is retried.
		lock_n = 1'b0;
		u_mst.xfer(`CMD_MEM_WR, 32'h8000_0040, 32'h0000_0007, 4'h0, 1'b0, 2'b00, rd_word, ok);
		`CHK(ok, 1'b1)
		repeat (3) @(posedge ref_clk);
		u_mst.xfer(`CMD_MEM_WR, 32'h8000_0044, 32'h0000_0008, 4'h0, 1'b0, 2'b00, rd_word, ok);
		`CHK({ok, stop_bus, devsel_bus}, 3'b000)
		lock_n = 1'b1;
		repeat (6) @(posedge ref_clk);
		#1;
		lock_n = 1'b0;
		u_mst.xfer(`CMD_MEM_WR, 32'h8000_0044, 32'h0000_0009, 4'h0, 1'b0, 2'b00, rd_word, ok);
		`CHK(ok, 1'b1)
		lock_n = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		$display("lock test done");
		irq_req = 1'b1;
		@(posedge ref_clk);
		#1;
		`CHK(inta_bus, 1'b0)
		irq_req = 1'b0;
		@(posedge ref_clk);
		#1;
		`CHK(inta_n_oe, 1'b0)
		irq_req = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		nrst = 1'b0;
		#1;
		`CHK({inta_n_oe, rd_ready, wr_valid}, 3'b000)
		repeat (4) @(posedge ref_clk);
		#1;
		irq_req = 1'b0;
		@(posedge ref_clk);
		#1;
		nrst = 1'b1;
		u_mst.xfer(`CMD_MEM_WR, 32'h8000_0020, 32'h0000_0003, 4'h0, 1'b0, 2'b00, rd_word, ok);
		`CHK(ok, 1'b0)
		$display("reset test done");
		test_done();
	end
endmodule
